// file: include/lane_mask_pkg.sv
package lane_mask_pkg;
   // =========================================
   // Word organisations
   typedef enum logic [1:0] {ORG_X8, ORG_X9, ORG_X18, ORG_X36} org_t;

   localparam int          MAX_WIDTH     = 36;
   localparam int          MAX_LANES     = 4;
   localparam int          NIBBLE_WIDTH  = 4;
   localparam int          LANE_WIDTH    = 9;
   localparam int          BEATS         = 2;
   localparam logic [3:0]  SEL_IDLE      = 4'hF;
   localparam logic [35:0] MASK_NONE     = 36'h000000000;

   // =========================================
   // Beat carried from pins to the array port
   typedef struct packed {
      logic        valid;
      logic        second;
      logic [35:0] data;
      logic [35:0] mask;
   } beat_t;

   typedef struct packed {
      logic        load_n;
      logic        rw;
      logic [3:0]  sel_n;
      logic [35:0] data;
   } pins_t;
endpackage

// file: rtl/lane_decode.sv
module lane_decode (
   input  wire lane_mask_pkg::org_t org,
   input  wire logic [3:0]          sel_n,
   output logic [35:0]              mask
);
   // =========================================
   // Per-lane decode, each select alone
   function automatic logic [35:0] lanes(input lane_mask_pkg::org_t o,
                                         input logic [3:0] s);
      logic [35:0] m;
      m = lane_mask_pkg::MASK_NONE;
      unique case (o)
         lane_mask_pkg::ORG_X8: begin
            m[3:0] = {lane_mask_pkg::NIBBLE_WIDTH{~s[0]}};
            m[7:4] = {lane_mask_pkg::NIBBLE_WIDTH{~s[1]}};
         end
         lane_mask_pkg::ORG_X9: begin
            m[8:0] = {lane_mask_pkg::LANE_WIDTH{~s[0]}};
         end
         lane_mask_pkg::ORG_X18: begin
            m[8:0]  = {lane_mask_pkg::LANE_WIDTH{~s[0]}};
            m[17:9] = {lane_mask_pkg::LANE_WIDTH{~s[1]}};
         end
         lane_mask_pkg::ORG_X36: begin
            for (int i = 0; i < lane_mask_pkg::MAX_LANES; i++) begin
               m[i*9 +: 9] = {lane_mask_pkg::LANE_WIDTH{~s[i]}};
            end
         end
      endcase
      return m;
   endfunction

   assign mask = lanes(org, sel_n);
endmodule

// file: rtl/sram_byte_write_mask.sv
// Behaviour
// - x8: select 0 low writes bits 3:0, select 1 low writes 7:4.
// - x8: upper select alone writes 7:4, keeps 3:0.
// - x18: select 0 writes bits 8:0, select 1 writes 17:9.
// - x9: single select low writes 8:0, high writes nothing.
// - x36: four selects control four 9-bit lanes in order.
// - x36: all four selects low store all 36 bits.
// - All selects high: location unchanged, write still proceeds.
// - Selects sampled per beat; each beat uses its own mask.
// - Masks apply only inside a started write; otherwise selects ignored.
// - Beat one at next clock rise, beat two at complement rise.
module sram_byte_write_mask (
   input  wire logic        SYS_CLK,
   input  wire logic        NRST,
   input  wire logic        CLK_EN,
   input  wire logic [1:0]  ORG_SEL,
   input  wire logic        POS_BEAT_STB,
   input  wire logic        NEG_BEAT_STB,
   input  wire logic        LOAD_STROBE_N,
   input  wire logic        RW_SEL,
   input  wire logic [3:0]  BYTE_LANE_WRITE_SEL_N,
   input  wire logic [35:0] WRITE_DATA,
   output logic             ARRAY_WR_VALID,
   output logic             ARRAY_WR_SECOND,
   output logic             ARRAY_WR_ACTIVE,
   output logic [35:0]      ARRAY_WR_DATA,
   output logic [35:0]      ARRAY_WR_MASK
);
   // =========================================
   // Reset release
   logic rst_meta_reg;
   logic rst_n_reg;

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // =========================================
   // Pin synchronisers
   lane_mask_pkg::pins_t pins_meta_reg;
   lane_mask_pkg::pins_t pins_reg;
   logic [1:0]           org_meta_reg;
   logic [1:0]           org_reg;
   logic [1:0]           stb_meta_reg;
   logic [1:0]           stb_reg;
   lane_mask_pkg::pins_t pins_in;

   assign pins_in = '{load_n: LOAD_STROBE_N, rw: RW_SEL,
                      sel_n: BYTE_LANE_WRITE_SEL_N, data: WRITE_DATA};

   always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pins_meta_reg <= '{load_n: 1'b1, rw: 1'b1, sel_n: lane_mask_pkg::SEL_IDLE,
                            data: lane_mask_pkg::MASK_NONE};
         pins_reg      <= '{load_n: 1'b1, rw: 1'b1, sel_n: lane_mask_pkg::SEL_IDLE,
                            data: lane_mask_pkg::MASK_NONE};
         org_meta_reg  <= 2'h0;
         org_reg       <= 2'h0;
         stb_meta_reg  <= 2'h0;
         stb_reg       <= 2'h0;
      end else if (CLK_EN) begin
         pins_meta_reg <= pins_in;
         pins_reg      <= pins_meta_reg;
         org_meta_reg  <= ORG_SEL;
         org_reg       <= org_meta_reg;
         stb_meta_reg  <= {NEG_BEAT_STB, POS_BEAT_STB};
         stb_reg       <= stb_meta_reg;
      end
   end

   // =========================================
   // Beat strobe edges
   logic [1:0] stb_last_reg;
   wire        pos_rise = stb_reg[0] & ~stb_last_reg[0];
   wire        neg_rise = stb_reg[1] & ~stb_last_reg[1];

   always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         stb_last_reg <= 2'h0;
      end else if (CLK_EN) begin
         stb_last_reg <= stb_reg;
      end
   end

   // =========================================
   // Write sequence tracking
   typedef enum logic [1:0] {IDLE, WAIT_FIRST, WAIT_SECOND} seq_t;
   seq_t seq_reg;
   seq_t seq_next;

   wire write_start = pos_rise & ~pins_reg.load_n & ~pins_reg.rw;
   wire take_first  = (seq_reg == WAIT_FIRST) & pos_rise;
   wire take_second = (seq_reg == WAIT_SECOND) & neg_rise;
   wire take_beat   = take_first | take_second;

   always_comb begin
      seq_next = seq_reg;
      unique case (seq_reg)
         IDLE: begin
            if (write_start) begin
               seq_next = WAIT_FIRST;
            end
         end
         WAIT_FIRST: begin
            if (take_first) begin
               seq_next = WAIT_SECOND;
            end
         end
         WAIT_SECOND: begin
            if (take_second) begin
               seq_next = IDLE;
            end
         end
         default: begin
            seq_next = IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         seq_reg <= IDLE;
      end else if (CLK_EN) begin
         seq_reg <= seq_next;
      end
   end

   // =========================================
   // Lane decode of the current beat
   logic [35:0] beat_mask;

   lane_decode u_decode (
      .org   (lane_mask_pkg::org_t'(org_reg)),
      .sel_n (pins_reg.sel_n),
      .mask  (beat_mask)
   );

   // =========================================
   // Array write port
   lane_mask_pkg::beat_t beat_reg;
   logic                 active_reg;

   always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         beat_reg   <= '{valid: 1'b0, second: 1'b0, data: lane_mask_pkg::MASK_NONE,
                         mask: lane_mask_pkg::MASK_NONE};
         active_reg <= 1'b0;
      end else if (CLK_EN) begin
         beat_reg.valid  <= take_beat;
         beat_reg.second <= take_second;
         beat_reg.data   <= take_beat ? pins_reg.data : lane_mask_pkg::MASK_NONE;
         beat_reg.mask   <= take_beat ? beat_mask : lane_mask_pkg::MASK_NONE;
         active_reg      <= seq_next != IDLE;
      end
   end

   assign ARRAY_WR_VALID  = beat_reg.valid;
   assign ARRAY_WR_SECOND = beat_reg.second;
   assign ARRAY_WR_DATA   = beat_reg.data;
   assign ARRAY_WR_MASK   = beat_reg.mask;
   assign ARRAY_WR_ACTIVE = active_reg;

   // =========================================
   // Checks
   sequence first_beat_s;
      CLK_EN && take_first;
   endsequence

   mask_idle_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
      (CLK_EN && !take_beat) |=> (ARRAY_WR_MASK == lane_mask_pkg::MASK_NONE))
      else $error("mask set outside a write beat");

   x8_lower_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
      (CLK_EN && take_beat && org_reg == 2'h0)
      |=> (ARRAY_WR_MASK[3:0] == {4{~$past(pins_reg.sel_n[0])}}))
      else $error("x8 lower nibble mask wrong");

   x8_upper_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
      (CLK_EN && take_beat && org_reg == 2'h0 && pins_reg.sel_n[1:0] == 2'h1)
      |=> (ARRAY_WR_MASK == 36'h0000000F0))
      else $error("x8 upper only mask wrong");

   x18_lanes_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
      (CLK_EN && take_beat && org_reg == 2'h2)
      |=> (ARRAY_WR_MASK[17:9] == {9{~$past(pins_reg.sel_n[1])}}))
      else $error("x18 upper byte mask wrong");

   x9_word_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
      (CLK_EN && take_beat && org_reg == 2'h1)
      |=> (ARRAY_WR_MASK == {27'h0, {9{~$past(pins_reg.sel_n[0])}}}))
      else $error("x9 mask wrong");

   x36_lane_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
      (CLK_EN && take_beat && org_reg == 2'h3)
      |=> (ARRAY_WR_MASK[35:27] == {9{~$past(pins_reg.sel_n[3])}}))
      else $error("x36 top lane mask wrong");

   x36_full_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
      (CLK_EN && take_beat && org_reg == 2'h3 && pins_reg.sel_n == 4'h0)
      |=> (ARRAY_WR_MASK == 36'hFFFFFFFFF))
      else $error("x36 full write mask wrong");

   all_high_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
      (CLK_EN && take_beat && pins_reg.sel_n == 4'hF)
      |=> (ARRAY_WR_VALID && ARRAY_WR_MASK == 36'h0))
      else $error("masked beat not empty");

   beat_order_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_reg)
      first_beat_s |=> (ARRAY_WR_VALID && !ARRAY_WR_SECOND && ARRAY_WR_ACTIVE))
      else $error("first beat wrongly flagged");
endmodule

// file: tb/ctrl_model.sv
module ctrl_model (
   input  wire logic        clk,
   output logic             pos,
   output logic             neg,
   output logic             load_n,
   output logic             rw,
   output logic [3:0]       sel_n,
   output logic [35:0]      data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      pos = 1'b0;
      neg = 1'b0;
      load_n = 1'b1;
      rw = 1'b1;
      sel_n = 4'hF;
      data = 36'h0;
   end
   // =========================================
   // Hold n cycles; outside beats lanes show changing junk
   task automatic step(input int n, input bit junk);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         if (junk && i < n - 1) begin
            sel_n = ~sel_n;
            data = ~data;
         end
      end
   endtask
   // =========================================
   // One burst: start, first beat on pos rise, second on neg rise
   task automatic write(input logic wr, input logic [3:0] s0, input logic [3:0] s1,
                        input logic [35:0] d0, input logic [35:0] d1);
      @(negedge clk);
      load_n = 1'b0;
      rw = ~wr;
      pos = 1'b1;
      step(3, 1);
      load_n = 1'b1;
      rw = 1'b1;
      pos = 1'b0;
      step(3, 1);
      sel_n = s0;
      data = d0;
      pos = 1'b1;
      step(3, 0);
      pos = 1'b0;
      step(3, 1);
      sel_n = s1;
      data = d1;
      neg = 1'b1;
      step(3, 0);
      neg = 1'b0;
      step(3, 1);
   endtask
endmodule

// file: tb/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  sys_clk = 1'b0;
   logic                  nrst = 1'b0;
   logic [1:0]            org_sel = 2'h0;
   logic                  clk_en = 1'b1;
   logic                  pos, neg, load_n, rw, valid, second, active;
   logic [3:0]            sel_n, s0, s1;
   logic [35:0]           data, d0, d1, wr_data, wr_mask;
   lane_mask_pkg::beat_t  exp_q[$];
   logic [3:0]            corner[6] = '{4'h0, 4'hF, 4'hE, 4'hD, 4'hB, 4'h7};
   int                    n_mismatch = 0;
   int                    n_tests = 0;
   int                    seed = 50949;
   always #5 sys_clk = ~sys_clk;
   ctrl_model u_ctrl (.clk(sys_clk), .pos(pos), .neg(neg), .load_n(load_n), .rw(rw),
                      .sel_n(sel_n), .data(data));
   sram_byte_write_mask dut (.SYS_CLK(sys_clk), .NRST(nrst), .CLK_EN(clk_en),
      .ORG_SEL(org_sel), .POS_BEAT_STB(pos), .NEG_BEAT_STB(neg), .LOAD_STROBE_N(load_n),
      .RW_SEL(rw), .BYTE_LANE_WRITE_SEL_N(sel_n), .WRITE_DATA(data),
      .ARRAY_WR_VALID(valid), .ARRAY_WR_SECOND(second), .ARRAY_WR_ACTIVE(active),
      .ARRAY_WR_DATA(wr_data), .ARRAY_WR_MASK(wr_mask));
   // =========================================
   // Expectations and compares
   function automatic logic [35:0] exp_mask(lane_mask_pkg::org_t o, logic [3:0] s);
      int w;
      int lw;
      logic [35:0] m;
      m = 36'h0;
      w = (o == lane_mask_pkg::ORG_X8) ? 8 : (o == lane_mask_pkg::ORG_X9) ? 9 :
          (o == lane_mask_pkg::ORG_X18) ? 18 : 36;
      lw = (o == lane_mask_pkg::ORG_X8) ? lane_mask_pkg::NIBBLE_WIDTH : lane_mask_pkg::LANE_WIDTH;
      for (int b = 0; b < w; b++) m[b] = ~s[b / lw];
      return m;
   endfunction
   function automatic logic [35:0] rnd36();
      logic [63:0] r;
      r = {$random(seed), $random(seed)};
      return r[35:0];
   endfunction
   task automatic chk_val(input logic [35:0] got, input logic [35:0] want);
      n_tests++;
      if (got !== want) begin
         $display("unexpected at %0t: got %h want %h", $time, got, want);
         n_mismatch++;
      end
   endtask
   task automatic chk_bit(input logic got, input logic want);
      n_tests++;
      if (got !== want) begin
         $display("unexpected at %0t: flag %b want %b", $time, got, want);
         n_mismatch++;
      end
   endtask
   task automatic exp_beat(input logic sec, input logic [35:0] d, input logic [3:0] s);
      exp_q.push_back('{valid: 1'b1, second: sec, data: d,
                        mask: exp_mask(lane_mask_pkg::org_t'(org_sel), s)});
   endtask
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // =========================================
   // Monitor: each array beat against the queue
   always @(negedge sys_clk) begin : mon
      lane_mask_pkg::beat_t e;
      if (valid === 1'b1) begin
         chk_bit(exp_q.size() > 0, 1'b1);
         if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk_bit(second, e.second);
            chk_val(wr_mask, e.mask);
            chk_val(wr_data, e.data);
            chk_bit(active, ~e.second);
         end
      end else begin
         chk_val(wr_mask | wr_data, 36'h0);
      end
   end
   initial begin
      repeat (30000) @(posedge sys_clk);
      $display("unexpected at %0t: run too long", $time);
      n_mismatch++;
      end_of_test;
   end
   // =========================================
   // Main sequence: every organisation, corners then random
   initial begin
      repeat (20) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (4) @(negedge sys_clk);
      for (int o = 0; o < 4; o++) begin
         org_sel = o[1:0];
         repeat (4) @(negedge sys_clk);
         for (int k = 0; k < 10; k++) begin
            s0 = (k < 6) ? corner[k] : 4'($random(seed));
            s1 = (k < 6) ? corner[5 - k] : 4'($random(seed));
            d0 = rnd36();
            d1 = rnd36();
            if (k != 9) begin
               exp_beat(1'b0, d0, s0);
               exp_beat(1'b1, d1, s1);
            end
            fork
               u_ctrl.write(k != 9, s0, s1, d0, d1);
               if (k == 5) begin
                  // Freeze between start and first beat; state must hold
                  repeat (5) @(negedge sys_clk);
                  clk_en = 1'b0;
                  @(negedge sys_clk);
                  chk_bit(active, 1'b1);
                  @(negedge sys_clk);
                  clk_en = 1'b1;
               end
            join
         end
         repeat (6) @(negedge sys_clk);
         chk_bit(exp_q.size() == 0, 1'b1);
         $display("test org %0d done", o);
      end
      end_of_test;
   end
endmodule
